/* common/psup_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the protection supervisor
// Assumes: 20 MHz system clock
// Notes: Offsets are byte addresses of aligned 32-bit words
`ifndef PSUP_CONSTS_SVH
`define PSUP_CONSTS_SVH
`define PSUP_CLK_HZ 20000000
`define PSUP_A_CTRL 8'h00
`define PSUP_A_STATUS 8'h04
`define PSUP_A_RECORD 8'h08
`define PSUP_A_STARTUP 8'h0c
`define PSUP_A_OPP1 8'h10
`define PSUP_A_OPP2 8'h14
`define PSUP_A_RESTART 8'h18
`define PSUP_A_FLR 8'h1c
`define PSUP_A_CFG 8'h20
`define PSUP_A_CUST 8'h24
`define PSUP_A_MEMCMD 8'h28
`define PSUP_A_MEMDATA 8'h2c
`define PSUP_CFG_DEFAULT 32'h0000_0000
`define PSUP_CFG_OPP1_EN 0
`define PSUP_CFG_OPP2_EN 1
`define PSUP_CFG_MODE_LO 2
`define PSUP_CFG_LOW_START 4
`define PSUP_CFG_RDLOCK 5
`define PSUP_CFG_WRLOCK 6
`define PSUP_CFG_BO_EN 7
`define PSUP_CFG_OVPB_EN 8
`define PSUP_CFG_CNT_LO 12
`define PSUP_STARTUP_DEF 32'h0010_0000
`define PSUP_OPP1_DEF 32'h0004_0000
`define PSUP_OPP2_DEF 32'h0010_0000
`define PSUP_RESTART_DEF 32'h0020_0000
`define PSUP_FLR_DEF 32'h0002_0000
`define PSUP_CUST_DEF 32'h0000_0000
`define PSUP_CMD_READ 2'h1
`define PSUP_CMD_WRITE 2'h2
`define PSUP_CMD_DEFAULT 2'h3
`define PSUP_CLEAR_SECONDS 65
`define PSUP_RAMP_STEP 8'h01
`endif

/* common/psup_pkg.sv */
// Purpose: Types of the protection supervisor
// Assumes: Nothing beyond the constants header
// Notes: States are one-hot
package psup_pkg;
	typedef enum logic [4:0] {
		PSUP_IDLE = 5'b00001,
		PSUP_PFC_START = 5'b00010,
		PSUP_LLC_START = 5'b00100,
		PSUP_RUN = 5'b01000,
		PSUP_PROT = 5'b10000
	} psup_state_type;
	typedef enum logic [1:0] {
		PSUP_LATCHED = 2'h0,
		PSUP_SAFE = 2'h1,
		PSUP_LATCH_AFTER = 2'h2
	} psup_resp_type;
	typedef struct packed {
		logic boost_start;
		logic boost_detect;
		logic boost_ovp_warn;
		logic in_reg;
		logic over_max;
		logic over_opp1;
		logic over_opp2;
		logic otp_warn;
		logic brownout;
		logic bo_stop_warn;
		logic hard_fault;
	} psup_sense_type;
endpackage

/* core/psup_supervisor.sv */
// Purpose: Start-up sequencing, timed overpower, protection responses, power good, config locks
// Assumes: Sense inputs are asynchronous comparator levels; chip supply UVLO drives RESET_N_I
// Notes: Registers over classic Wishbone, one wait state per access
// Functional notes
// - PFC first, LLC after boost start level
// - Start-up timeout protects with overpower response
// - Above maximum power limit per cycle
// - First overpower timer stops both, protects
// - Second overpower timer likewise, separately disableable
// - Response latched, safe restart, or latch-after
// - Latched waits for fast reset or UVLO
// - One shared safe restart delay
// - Repeat counter counts triggers, latches at limit
// - Repeat counter clears after 65 quiet seconds
// - Long brownout restarts, even from latched
// - Feedback pin high, low once running
// - Warnings raise the feedback pin level
// - Warning level changes follow a ramp
// - Hard faults pull pin high instantly
// - Protection record sticky until software clears
// - Start threshold selectable 12 V or 19 V
// - Low start threshold disables drain charging
// - Read lock hides memory; default clears
// - Write lock refuses config, customer code and memory writes; default clears
// - Default load restores every parameter except customer code, unlocks
// - Customer code always readable
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`include "psup_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module psup_supervisor #(
	parameter int unsigned CLEAR_CYCLES = `PSUP_CLEAR_SECONDS * `PSUP_CLK_HZ,
	parameter int unsigned MEM_WORDS = 16
) (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Analog comparator levels
	input wire psup_pkg::psup_sense_type SENSE_I,
	// Converter control
	output logic PFC_EN_O,
	output logic LLC_EN_O,
	output logic POWER_LIMIT_O,
	output logic START_LEVEL_LOW_O,
	output logic DRAIN_CHARGE_EN_O,
	// Feedback sense pin level, 0 low to ff high
	output logic [7:0] FB_LEVEL_O
);
	psup_pkg::psup_sense_type s_meta_ff, s_ff;
	psup_pkg::psup_state_type state_ff, nxt_state;
	logic [31:0] cfg_ff, nxt_cfg, startup_ff, nxt_startup, opp1_ff, nxt_opp1;
	logic [31:0] opp2_ff, nxt_opp2, restart_ff, nxt_restart, flr_ff, nxt_flr;
	logic [31:0] cust_ff, nxt_cust, tmr_ff, nxt_tmr, t1_ff, nxt_t1, t2_ff, nxt_t2;
	logic [31:0] bo_ff, nxt_bo, quiet_ff, nxt_quiet, rd_ff, nxt_rd;
	logic [3:0] rep_ff, nxt_rep;
	logic [3:0] rec_ff, nxt_rec;
	logic latched_ff, nxt_latched, ack_ff, nxt_ack;
	logic [7:0] fb_ff, nxt_fb;
	logic [3:0] maddr_ff, nxt_maddr;
	logic [31:0] mem_ff [MEM_WORDS];
	logic wr_denied_ff, nxt_wr_denied;
	logic access, wr, trig, warn;
	logic [3:0] trig_src;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	assign access = WB_CYC_I && WB_STB_I && !ack_ff;
	assign wr = access && WB_WE_I;

	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = tmr_ff;
		nxt_t1 = t1_ff;
		nxt_t2 = t2_ff;
		nxt_bo = bo_ff;
		nxt_quiet = quiet_ff;
		nxt_rep = rep_ff;
		nxt_latched = latched_ff;
		nxt_rec = rec_ff;
		trig = 1'b0;
		trig_src = 4'h0;
		// Overpower timers run only in the run state
		if (state_ff == psup_pkg::PSUP_RUN && cfg_ff[`PSUP_CFG_OPP1_EN] && s_ff.over_opp1) begin
			nxt_t1 = t1_ff + 32'h1;
		end else begin
			nxt_t1 = 32'h0;
		end
		if (state_ff == psup_pkg::PSUP_RUN && cfg_ff[`PSUP_CFG_OPP2_EN] && s_ff.over_opp2) begin
			nxt_t2 = t2_ff + 32'h1;
		end else begin
			nxt_t2 = 32'h0;
		end
		unique case (state_ff)
			psup_pkg::PSUP_IDLE: begin
				nxt_tmr = 32'h0;
				nxt_state = psup_pkg::PSUP_PFC_START;
			end
			psup_pkg::PSUP_PFC_START, psup_pkg::PSUP_LLC_START: begin
				nxt_tmr = tmr_ff + 32'h1;
				if (state_ff == psup_pkg::PSUP_PFC_START && s_ff.boost_start) begin
					nxt_state = psup_pkg::PSUP_LLC_START;
				end
				if (state_ff == psup_pkg::PSUP_LLC_START && s_ff.in_reg) begin
					nxt_state = psup_pkg::PSUP_RUN;
				end else if (tmr_ff >= startup_ff) begin
					trig = 1'b1;
					trig_src = 4'h1;
				end
			end
			psup_pkg::PSUP_RUN: begin
				if (t1_ff >= opp1_ff && cfg_ff[`PSUP_CFG_OPP1_EN]) begin
					trig = 1'b1;
					trig_src = 4'h2;
				end else if (t2_ff >= opp2_ff && cfg_ff[`PSUP_CFG_OPP2_EN]) begin
					trig = 1'b1;
					trig_src = 4'h4;
				end
			end
			psup_pkg::PSUP_PROT: begin
				nxt_tmr = tmr_ff + 32'h1;
				if (!latched_ff && tmr_ff >= restart_ff) begin
					nxt_state = psup_pkg::PSUP_IDLE;
				end
			end
		endcase
		if (state_ff != psup_pkg::PSUP_IDLE && s_ff.hard_fault) begin
			trig = 1'b1;
			trig_src = 4'h8;
		end
		// Fast latch reset counts brownout time in any state
		nxt_bo = s_ff.brownout ? bo_ff + 32'h1 : 32'h0;
		if (state_ff == psup_pkg::PSUP_PROT && bo_ff >= flr_ff) begin
			nxt_latched = 1'b0;
			nxt_state = psup_pkg::PSUP_IDLE;
			nxt_bo = 32'h0;
		end
		nxt_quiet = (quiet_ff < CLEAR_CYCLES) ? quiet_ff + 32'h1 : quiet_ff;
		if (quiet_ff >= CLEAR_CYCLES) begin
			nxt_rep = 4'h0;
		end
		if (wr && WB_ADR_I == `PSUP_A_RECORD) begin
			nxt_rec = rec_ff & ~WB_DAT_I[3:0];
		end
		if (trig && state_ff != psup_pkg::PSUP_PROT) begin
			nxt_state = psup_pkg::PSUP_PROT;
			nxt_tmr = 32'h0;
			nxt_quiet = 32'h0;
			nxt_rec = nxt_rec | trig_src;
			unique case (psup_pkg::psup_resp_type'(cfg_ff[`PSUP_CFG_MODE_LO +: 2]))
				psup_pkg::PSUP_LATCHED: nxt_latched = 1'b1;
				psup_pkg::PSUP_SAFE: nxt_latched = 1'b0;
				psup_pkg::PSUP_LATCH_AFTER: begin
					nxt_rep = rep_ff + 4'h1;
					nxt_latched = (rep_ff + 4'h1) >= cfg_ff[`PSUP_CFG_CNT_LO +: 4];
				end
				default: nxt_latched = 1'b1;
			endcase
		end
	end

	// Power good level and warning ramp
	always_comb begin
		warn = !s_ff.boost_detect || (t1_ff >= (opp1_ff >> 1) && t1_ff != 32'h0)
			|| s_ff.otp_warn || (s_ff.boost_ovp_warn && cfg_ff[`PSUP_CFG_OVPB_EN])
			|| (s_ff.bo_stop_warn && cfg_ff[`PSUP_CFG_BO_EN]);
		if (state_ff != psup_pkg::PSUP_RUN) begin
			nxt_fb = 8'hff;
		end else if (warn && fb_ff != 8'hff) begin
			nxt_fb = fb_ff + `PSUP_RAMP_STEP;
		end else if (!warn && fb_ff != 8'h00) begin
			nxt_fb = fb_ff - `PSUP_RAMP_STEP;
		end else begin
			nxt_fb = fb_ff;
		end
	end

	// Register writes and config memory
	always_comb begin
		nxt_ack = access;
		nxt_cfg = cfg_ff;
		nxt_startup = startup_ff;
		nxt_opp1 = opp1_ff;
		nxt_opp2 = opp2_ff;
		nxt_restart = restart_ff;
		nxt_flr = flr_ff;
		nxt_cust = cust_ff;
		nxt_maddr = maddr_ff;
		nxt_wr_denied = wr_denied_ff;
		nxt_rd = rd_ff;
		if (wr) begin
			unique case (WB_ADR_I)
				`PSUP_A_CFG: begin
					if (!cfg_ff[`PSUP_CFG_WRLOCK]) begin
						nxt_cfg = merge(cfg_ff, WB_DAT_I, WB_SEL_I);
					end
				end
				`PSUP_A_STARTUP: nxt_startup = merge(startup_ff, WB_DAT_I, WB_SEL_I);
				`PSUP_A_OPP1: nxt_opp1 = merge(opp1_ff, WB_DAT_I, WB_SEL_I);
				`PSUP_A_OPP2: nxt_opp2 = merge(opp2_ff, WB_DAT_I, WB_SEL_I);
				`PSUP_A_RESTART: nxt_restart = merge(restart_ff, WB_DAT_I, WB_SEL_I);
				`PSUP_A_FLR: nxt_flr = merge(flr_ff, WB_DAT_I, WB_SEL_I);
				`PSUP_A_CUST: begin
					if (!cfg_ff[`PSUP_CFG_WRLOCK]) begin
						nxt_cust = merge(cust_ff, WB_DAT_I, WB_SEL_I);
					end
				end
				`PSUP_A_MEMCMD: begin
					nxt_maddr = WB_DAT_I[11:8];
					nxt_wr_denied = 1'b0;
					if (WB_DAT_I[1:0] == `PSUP_CMD_DEFAULT) begin
						nxt_cfg = `PSUP_CFG_DEFAULT;
						nxt_startup = `PSUP_STARTUP_DEF;
						nxt_opp1 = `PSUP_OPP1_DEF;
						nxt_opp2 = `PSUP_OPP2_DEF;
						nxt_restart = `PSUP_RESTART_DEF;
						nxt_flr = `PSUP_FLR_DEF;
					end else if (WB_DAT_I[1:0] == `PSUP_CMD_WRITE && cfg_ff[`PSUP_CFG_WRLOCK]) begin
						nxt_wr_denied = 1'b1;
					end else if (WB_DAT_I[1:0] == `PSUP_CMD_READ) begin
						nxt_rd = cfg_ff[`PSUP_CFG_RDLOCK] ? 32'h0 : mem_ff[WB_DAT_I[11:8]];
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				mem_ff[i] <= 32'h0;
			end
		end else if (wr && WB_ADR_I == `PSUP_A_MEMDATA && !cfg_ff[`PSUP_CFG_WRLOCK]) begin
			mem_ff[maddr_ff] <= merge(mem_ff[maddr_ff], WB_DAT_I, WB_SEL_I);
		end else if (wr && WB_ADR_I == `PSUP_A_MEMCMD && WB_DAT_I[1:0] == `PSUP_CMD_DEFAULT) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				mem_ff[i] <= 32'h0;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s_meta_ff <= '0;
			s_ff <= '0;
			state_ff <= psup_pkg::PSUP_IDLE;
			tmr_ff <= 32'h0;
			t1_ff <= 32'h0;
			t2_ff <= 32'h0;
			bo_ff <= 32'h0;
			quiet_ff <= 32'h0;
			rep_ff <= 4'h0;
			latched_ff <= 1'b0;
			rec_ff <= 4'h0;
			fb_ff <= 8'hff;
			ack_ff <= 1'b0;
			cfg_ff <= `PSUP_CFG_DEFAULT;
			startup_ff <= `PSUP_STARTUP_DEF;
			opp1_ff <= `PSUP_OPP1_DEF;
			opp2_ff <= `PSUP_OPP2_DEF;
			restart_ff <= `PSUP_RESTART_DEF;
			flr_ff <= `PSUP_FLR_DEF;
			cust_ff <= `PSUP_CUST_DEF;
			maddr_ff <= 4'h0;
			wr_denied_ff <= 1'b0;
			rd_ff <= 32'h0;
		end else begin
			s_meta_ff <= SENSE_I;
			s_ff <= s_meta_ff;
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			t1_ff <= nxt_t1;
			t2_ff <= nxt_t2;
			bo_ff <= nxt_bo;
			quiet_ff <= nxt_quiet;
			rep_ff <= nxt_rep;
			latched_ff <= nxt_latched;
			rec_ff <= nxt_rec;
			fb_ff <= nxt_fb;
			ack_ff <= nxt_ack;
			cfg_ff <= nxt_cfg;
			startup_ff <= nxt_startup;
			opp1_ff <= nxt_opp1;
			opp2_ff <= nxt_opp2;
			restart_ff <= nxt_restart;
			flr_ff <= nxt_flr;
			cust_ff <= nxt_cust;
			maddr_ff <= nxt_maddr;
			wr_denied_ff <= nxt_wr_denied;
			rd_ff <= nxt_rd;
		end
	end

	// Read mux; timer settings hidden under read lock, config and customer code never
	always_comb begin
		unique case (WB_ADR_I)
			`PSUP_A_CTRL: WB_DAT_O = {27'h0, state_ff};
			`PSUP_A_STATUS: WB_DAT_O = {19'h0, wr_denied_ff, 2'h0, rep_ff, latched_ff,
				fb_ff[7:0] != 8'h00, LLC_EN_O, PFC_EN_O, rec_ff != 4'h0, 1'b0};
			`PSUP_A_RECORD: WB_DAT_O = {28'h0, rec_ff};
			`PSUP_A_CFG: WB_DAT_O = cfg_ff;
			`PSUP_A_STARTUP: WB_DAT_O = cfg_ff[`PSUP_CFG_RDLOCK] ? 32'h0 : startup_ff;
			`PSUP_A_OPP1: WB_DAT_O = cfg_ff[`PSUP_CFG_RDLOCK] ? 32'h0 : opp1_ff;
			`PSUP_A_OPP2: WB_DAT_O = cfg_ff[`PSUP_CFG_RDLOCK] ? 32'h0 : opp2_ff;
			`PSUP_A_RESTART: WB_DAT_O = cfg_ff[`PSUP_CFG_RDLOCK] ? 32'h0 : restart_ff;
			`PSUP_A_FLR: WB_DAT_O = cfg_ff[`PSUP_CFG_RDLOCK] ? 32'h0 : flr_ff;
			`PSUP_A_CUST: WB_DAT_O = cust_ff;
			`PSUP_A_MEMDATA: WB_DAT_O = rd_ff;
			default: WB_DAT_O = 32'h0;
		endcase
	end

	assign WB_ACK_O = ack_ff;
	assign PFC_EN_O = (state_ff != psup_pkg::PSUP_IDLE) && (state_ff != psup_pkg::PSUP_PROT);
	assign LLC_EN_O = (state_ff == psup_pkg::PSUP_LLC_START) || (state_ff == psup_pkg::PSUP_RUN);
	assign POWER_LIMIT_O = LLC_EN_O && s_ff.over_max;
	assign START_LEVEL_LOW_O = cfg_ff[`PSUP_CFG_LOW_START];
	assign DRAIN_CHARGE_EN_O = !cfg_ff[`PSUP_CFG_LOW_START];
	assign FB_LEVEL_O = fb_ff;
endmodule
`default_nettype wire

/* verification/psup_sup_assertions.sv */
// Purpose: Port checks of the protection supervisor
// Assumes: Bound to psup_supervisor
// Notes: Ramp check skips jumps to and from full level
`timescale 1ns/1ns
`default_nettype none
module psup_sup_assertions #(
	parameter int unsigned CLEAR_CYCLES = 200,
	parameter int unsigned MEM_WORDS = 16
) (
	// Clock, reset, bus
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Sense and control
	input wire psup_pkg::psup_sense_type SENSE_I,
	input wire logic PFC_EN_O,
	input wire logic LLC_EN_O,
	input wire logic POWER_LIMIT_O,
	input wire logic START_LEVEL_LOW_O,
	input wire logic DRAIN_CHARGE_EN_O,
	input wire logic [7:0] FB_LEVEL_O
);
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RESET_N_I);
	a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack missing");
	a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	a_llc_needs_pfc: assert property (LLC_EN_O |-> PFC_EN_O)
		else $error("llc without pfc");
	a_llc_rise_order: assert property ($rose(LLC_EN_O) |-> $past(PFC_EN_O))
		else $error("llc before pfc");
	a_limit_when_llc: assert property (POWER_LIMIT_O |-> LLC_EN_O)
		else $error("limit while off");
	a_drain_vs_start: assert property (DRAIN_CHARGE_EN_O != START_LEVEL_LOW_O)
		else $error("drain charge wrong");
	a_fb_stop_high: assert property ($fell(PFC_EN_O) |-> ##[0:1] FB_LEVEL_O == 8'hff)
		else $error("fb not high on stop");
	a_fb_start_high: assert property (!LLC_EN_O && !$past(LLC_EN_O) |-> FB_LEVEL_O == 8'hff)
		else $error("fb low before run");
	a_fb_ramp_step: assert property (LLC_EN_O && $past(LLC_EN_O) && FB_LEVEL_O != 8'hff
		&& $past(FB_LEVEL_O) != 8'hff |-> FB_LEVEL_O == $past(FB_LEVEL_O)
		|| FB_LEVEL_O == $past(FB_LEVEL_O) + 8'h01 || FB_LEVEL_O == $past(FB_LEVEL_O) - 8'h01)
		else $error("fb step too large");
	c_llc_start: cover property ($rose(LLC_EN_O));
	c_stop: cover property ($fell(PFC_EN_O));
	c_limit: cover property (POWER_LIMIT_O);
endmodule
bind psup_supervisor psup_sup_assertions #(.CLEAR_CYCLES(CLEAR_CYCLES), .MEM_WORDS(MEM_WORDS))
	u_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SENSE_I(SENSE_I),
	.PFC_EN_O(PFC_EN_O), .LLC_EN_O(LLC_EN_O), .POWER_LIMIT_O(POWER_LIMIT_O),
	.START_LEVEL_LOW_O(START_LEVEL_LOW_O), .DRAIN_CHARGE_EN_O(DRAIN_CHARGE_EN_O),
	.FB_LEVEL_O(FB_LEVEL_O));
`default_nettype wire

/* verification/psup_pg_model.sv */
// Purpose: Secondary power good stage behind the optocoupler
// Assumes: Half level is the transistor threshold
// Notes: No hysteresis, so ramps cross it once
`timescale 1ns/1ns
`default_nettype none
module psup_pg_model (
	// Feedback pin level in, power good out
	input wire logic [7:0] fb_level_i,
	output logic pg_o
);
	// High pin pulls power good low
	assign pg_o = fb_level_i < 8'h80;
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Scenario bench of the protection supervisor
// Assumes: Timers set to short counts first
// Notes: Byte lanes always full
`include "psup_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pfc, llc, plim, slow, drain, pg;
	logic [7:0] adr = 8'h00;
	logic [7:0] fb;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	psup_pkg::psup_sense_type sense = '0;
	int err_count = 0, n_tests = 0;
	psup_supervisor #(.CLEAR_CYCLES(200)) u_dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
		.WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SENSE_I(sense),
		.PFC_EN_O(pfc), .LLC_EN_O(llc), .POWER_LIMIT_O(plim), .START_LEVEL_LOW_O(slow),
		.DRAIN_CHARGE_EN_O(drain), .FB_LEVEL_O(fb));
	psup_pg_model u_pg (.fb_level_i(fb), .pg_o(pg));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Only the watchdog ends a missing answer
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = dat_o;
		chk(ack, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Bounded wait: 0 pfc, 1 llc, 2 feedback level
	task automatic wait_on(input int s, input logic [7:0] v);
		int i;
		for (i = 0; i < 3000; i++) begin
			if ((s == 0 ? {7'h0, pfc} : s == 1 ? {7'h0, llc} : fb) === v) break;
			@(posedge clk);
		end
	endtask
	task automatic s_startup_timeout();
		wait_on(0, 8'h01);
		repeat (50) @(posedge clk);
		chk(llc, 1'b0);
		wait_on(0, 8'h00);
		wb(1'b0, `PSUP_A_RECORD, 32'h0);
		chk(rdat[0], 1'b1);
		wait_on(0, 8'h01);
		chk(pfc, 1'b1);
		wb(1'b1, `PSUP_A_RECORD, 32'hf);
	endtask
	task automatic s_run();
		sense.boost_detect <= 1'b1;
		sense.boost_start <= 1'b1;
		sense.in_reg <= 1'b1;
		wait_on(1, 8'h01);
		chk(pfc, 1'b1);
		wait_on(2, 8'h00);
		chk(fb, 8'h00);
		chk(pg, 1'b1);
		sense.over_max <= 1'b1;
		sense.otp_warn <= 1'b1;
		repeat (20) @(posedge clk);
		chk(plim, 1'b1);
		chk(pfc, 1'b1);
		chk(fb != 8'h00 && fb != 8'hff, 1'b1);
		sense.over_max <= 1'b0;
		sense.otp_warn <= 1'b0;
		wait_on(2, 8'h00);
	endtask
	// Both levels exceeded, only level k enabled
	task automatic s_opp(input int k);
		wb(1'b1, `PSUP_A_CFG, 32'h4 | (32'h1 << k));
		sense.over_opp1 <= 1'b1;
		sense.over_opp2 <= 1'b1;
		wait_on(0, 8'h00);
		chk(llc, 1'b0);
		sense.over_opp1 <= 1'b0;
		sense.over_opp2 <= 1'b0;
		wb(1'b0, `PSUP_A_RECORD, 32'h0);
		chk(rdat[2:1], 2'h1 << k);
		wait_on(1, 8'h01);
		chk(pfc, 1'b1);
		wb(1'b0, `PSUP_A_RECORD, 32'h0);
		chk(rdat[2:1], 2'h1 << k);
		wb(1'b1, `PSUP_A_RECORD, 32'hf);
		wb(1'b0, `PSUP_A_RECORD, 32'h0);
		chk(rdat[3:0], 4'h0);
	endtask
	task automatic s_latched();
		wb(1'b1, `PSUP_A_CFG, 32'h0);
		sense.hard_fault <= 1'b1;
		wait_on(0, 8'h00);
		repeat (2) @(posedge clk);
		chk(fb, 8'hff);
		sense.hard_fault <= 1'b0;
		repeat (300) @(posedge clk);
		chk(pfc, 1'b0);
		wb(1'b0, `PSUP_A_RECORD, 32'h0);
		chk(rdat[3], 1'b1);
		sense.brownout <= 1'b1;
		repeat (20) @(posedge clk);
		sense.brownout <= 1'b0;
		wait_on(0, 8'h01);
		chk(pfc, 1'b1);
	endtask
	// Latch after two triggers, then quiet clear
	task automatic s_repeat();
		wb(1'b1, `PSUP_A_CFG, 32'h2008);
		repeat (2) begin
			wait_on(1, 8'h01);
			sense.hard_fault <= 1'b1;
			wait_on(0, 8'h00);
			sense.hard_fault <= 1'b0;
		end
		wb(1'b0, `PSUP_A_STATUS, 32'h0);
		chk(rdat[9:5], 5'h05);
		chk(rdat[1], 1'b1);
		repeat (100) @(posedge clk);
		chk(pfc, 1'b0);
		sense.brownout <= 1'b1;
		repeat (20) @(posedge clk);
		sense.brownout <= 1'b0;
		repeat (250) @(posedge clk);
		wb(1'b0, `PSUP_A_STATUS, 32'h0);
		chk(rdat[9:6], 4'h0);
	endtask
	task automatic s_locks();
		wb(1'b1, `PSUP_A_CFG, 32'h50);
		chk(slow, 1'b1);
		chk(drain, 1'b0);
		wb(1'b1, `PSUP_A_CUST, 32'ha5);
		wb(1'b0, `PSUP_A_CUST, 32'h0);
		chk(rdat, `PSUP_CUST_DEF);
		wb(1'b1, `PSUP_A_MEMCMD, {30'h0, `PSUP_CMD_DEFAULT});
		wb(1'b0, `PSUP_A_CFG, 32'h0);
		chk(rdat, `PSUP_CFG_DEFAULT);
		wb(1'b0, `PSUP_A_STARTUP, 32'h0);
		chk(rdat, `PSUP_STARTUP_DEF);
		wb(1'b1, `PSUP_A_CUST, 32'ha5);
		wb(1'b1, `PSUP_A_CFG, 32'h20);
		wb(1'b0, `PSUP_A_RESTART, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, `PSUP_A_CUST, 32'h0);
		chk(rdat, 32'ha5);
		wb(1'b1, `PSUP_A_MEMCMD, {30'h0, `PSUP_CMD_DEFAULT});
		wb(1'b0, `PSUP_A_RESTART, 32'h0);
		chk(rdat, `PSUP_RESTART_DEF);
		wb(1'b0, 8'h40, 32'h0);
		chk(rdat, 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b1, `PSUP_A_STARTUP, 32'hc8);
		wb(1'b1, `PSUP_A_OPP1, 32'h10);
		wb(1'b1, `PSUP_A_OPP2, 32'h10);
		wb(1'b1, `PSUP_A_RESTART, 32'h28);
		wb(1'b1, `PSUP_A_FLR, 32'ha);
		wb(1'b1, `PSUP_A_CFG, 32'h4);
		s_startup_timeout();
		s_run();
		s_opp(0);
		s_opp(1);
		s_latched();
		s_repeat();
		s_locks();
		close_out();
	end
	// Tests need about 1500 cycles
	initial begin
		#2000000;
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
